//--- dbr_seq.sv
// Debug break and resume sequencing for the core's exception unit.
// Assumes decoder steps, flag restores and mode events arrive on ref_clk.
// What this block does
// - Resume flag set on return suppresses the code breakpoint fault once.
// - Without resume flag an armed code breakpoint faults again to vector 1.
// - Breakpoint coinciding with another fault repeats once after that fault.
// - Hardware may set resume flag in stacked image; setting again is harmless.
// - String port output traps right after the iteration hitting the breakpoint.
// - String port input traps one iteration after the hitting one; on the last iteration it traps at once.
// - Code breakpoint on port instruction is taken before it executes.
// - With restart, return from management mode retakes port code breakpoint.
// - Halt code breakpoint taken before halt, and again after management return.
// - Management entry blocks NMI; allow flag plus delivered interrupt re-enables.
// - Any trap or fault inside management mode re-enables NMI.
`timescale 1ns/1ps
module dbr_seq (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Instruction steps from the decoder
  input  wire dbr_pkg::dbr_step_t step,
  input  wire logic               step_done,
  // Flag image and mode events
  input  wire logic               flags_restore,
  input  wire logic               restore_rf,
  input  wire logic               maskable_allow,
  input  wire logic               maskable_deliver,
  input  wire logic               management_interrupt,
  input  wire logic               management_mode_return,
  // Register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  // Outcomes
  output dbr_pkg::dbr_exc_t       exc,
  output logic                    resume_suppress_flag,
  output logic                    system_management_state,
  output logic                    nmi_blocked,
  output logic                    irq
);

  logic [1:0]                   ctrl_reg;
  logic [dbr_pkg::EV_WIDTH-1:0] ev_reg;
  logic [dbr_pkg::EV_WIDTH-1:0] en_reg;
  logic [dbr_pkg::EV_WIDTH-1:0] ev_set;
  logic                         extra_rep_reg;
  logic                         sin_pend_reg;
  logic                         io_smi_reg;
  dbr_pkg::dbr_exc_t            exc_next;
  logic                         brk_fire;
  logic                         nmi_reen;

  // Code breakpoint fires before execution unless suppressed
  always_comb
  begin
    brk_fire = step.valid && step.code_match
               && (!resume_suppress_flag || extra_rep_reg);
  end

  always_comb
  begin
    exc_next = '0;
    if (brk_fire)
    begin
      exc_next.code_fault = 1'b1;
    end
    else if (step.valid && step.other_fault)
    begin
      exc_next.other_fault = 1'b1;
      exc_next.stack_rf    = ctrl_reg[dbr_pkg::CTRL_AUTO_SUPP];
    end
    else if (step.valid && step.op == dbr_pkg::DBR_OP_SOUT && step.data_match)
    begin
      exc_next.data_trap = 1'b1;
    end
    else if (step.valid && step.op == dbr_pkg::DBR_OP_SIN
             && (sin_pend_reg || (step.data_match && step.last_iter)))
    begin
      exc_next.data_trap = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      exc <= '0;
    end
    else
    begin
      exc <= exc_next;
    end
  end

  // Input string trap waits one iteration; last iteration traps at once
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sin_pend_reg <= 1'b0;
    end
    else if (step.valid && step.op == dbr_pkg::DBR_OP_SIN && !brk_fire)
    begin
      sin_pend_reg <= step.data_match && !sin_pend_reg && !step.last_iter;
    end
  end

  // Resume flag: restored image, auto clear on step done
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      resume_suppress_flag <= 1'b0;
    end
    else if (flags_restore)
    begin
      resume_suppress_flag <= restore_rf;
    end
    else if (step_done)
    begin
      resume_suppress_flag <= 1'b0;
    end
  end

  // A coinciding fault leaves exactly one extra breakpoint repetition
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      extra_rep_reg <= 1'b0;
    end
    else if (step.valid && step.code_match && step.other_fault && !brk_fire)
    begin
      extra_rep_reg <= 1'b1;
    end
    else if (brk_fire || step_done)
    begin
      extra_rep_reg <= 1'b0;
    end
  end

  // Management mode and NMI gating
  assign nmi_reen = system_management_state
                    && ((maskable_allow && maskable_deliver)
                        || exc_next.code_fault || exc_next.data_trap
                        || exc_next.other_fault);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      system_management_state <= 1'b0;
      nmi_blocked             <= 1'b0;
      io_smi_reg              <= 1'b0;
    end
    else if (management_interrupt && !system_management_state)
    begin
      system_management_state <= 1'b1;
      nmi_blocked             <= 1'b1;
      io_smi_reg              <= ctrl_reg[dbr_pkg::CTRL_IO_RESTART]
                                 && step.valid && step.op == dbr_pkg::DBR_OP_PORT;
    end
    else if (management_mode_return && system_management_state)
    begin
      system_management_state <= 1'b0;
      nmi_blocked             <= 1'b0;
      io_smi_reg              <= 1'b0;
    end
    else if (nmi_reen)
    begin
      nmi_blocked <= 1'b0;
    end
  end

  // Register file and interrupt
  always_comb
  begin
    ev_set = '0;
    ev_set[dbr_pkg::EV_CODE_BRK]  = exc_next.code_fault;
    ev_set[dbr_pkg::EV_DATA_BRK]  = exc_next.data_trap;
    ev_set[dbr_pkg::EV_SMM_ENTRY] = management_interrupt && !system_management_state;
    ev_set[dbr_pkg::EV_NMI_REEN]  = nmi_reen && nmi_blocked;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_reg <= dbr_pkg::CTRL_RESET;
      en_reg   <= dbr_pkg::EV_RESET;
      ev_reg   <= dbr_pkg::EV_RESET;
    end
    else
    begin
      if (reg_wr && reg_addr == dbr_pkg::ADDR_CTRL)
      begin
        ctrl_reg <= reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == dbr_pkg::ADDR_IRQ_EN)
      begin
        en_reg <= reg_wdata[dbr_pkg::EV_WIDTH-1:0];
      end
      // Set wins over a same-cycle clear
      if (reg_wr && reg_addr == dbr_pkg::ADDR_IRQ_CL)
      begin
        ev_reg <= (ev_reg & ~reg_wdata[dbr_pkg::EV_WIDTH-1:0]) | ev_set;
      end
      else
      begin
        ev_reg <= ev_reg | ev_set;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      irq       <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      irq       <= |(ev_reg & en_reg);
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          dbr_pkg::ADDR_CTRL:   reg_rdata <= {30'h0, ctrl_reg};
          dbr_pkg::ADDR_STATUS: reg_rdata <= {27'h0, io_smi_reg, extra_rep_reg, nmi_blocked,
                                              system_management_state, resume_suppress_flag};
          dbr_pkg::ADDR_IRQ_ST: reg_rdata <= {28'h0, ev_reg};
          dbr_pkg::ADDR_IRQ_EN: reg_rdata <= {28'h0, en_reg};
          default:              reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Checks
  code_fault_a: assert property (@(posedge ref_clk) disable iff (rst)
    step.valid && step.code_match && !resume_suppress_flag |=> exc.code_fault)
    else $error("code breakpoint not faulted");
  suppress_a: assert property (@(posedge ref_clk) disable iff (rst)
    step.valid && resume_suppress_flag && !extra_rep_reg |=> !exc.code_fault)
    else $error("suppressed breakpoint faulted");
  extra_rep_a: assert property (@(posedge ref_clk) disable iff (rst)
    extra_rep_reg && step.valid && step.code_match |=> exc.code_fault)
    else $error("extra repetition missing");
  sout_trap_a: assert property (@(posedge ref_clk) disable iff (rst)
    step.valid && step.op == dbr_pkg::DBR_OP_SOUT && step.data_match && !step.code_match
    && !step.other_fault |=> exc.data_trap)
    else $error("output string trap late");
  sin_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
    step.valid && step.op == dbr_pkg::DBR_OP_SIN && step.data_match && !sin_pend_reg
    && !step.last_iter |=> !exc.data_trap)
    else $error("input string trap early");
  sin_late_a: assert property (@(posedge ref_clk) disable iff (rst)
    step.valid && step.op == dbr_pkg::DBR_OP_SIN && sin_pend_reg && !step.code_match
    && !step.other_fault |=> exc.data_trap)
    else $error("delayed input string trap missing");
  sin_last_a: assert property (@(posedge ref_clk) disable iff (rst)
    step.valid && step.op == dbr_pkg::DBR_OP_SIN && step.data_match && step.last_iter
    && !step.code_match && !step.other_fault |=> exc.data_trap)
    else $error("last input iteration trap missing");
  stack_rf_a: assert property (@(posedge ref_clk) disable iff (rst)
    step.valid && step.other_fault && !step.code_match && ctrl_reg[dbr_pkg::CTRL_AUTO_SUPP]
    |=> exc.other_fault && exc.stack_rf)
    else $error("stacked resume flag not set");
  io_halt_brk_a: assert property (@(posedge ref_clk) disable iff (rst)
    step.valid && (step.op == dbr_pkg::DBR_OP_PORT || step.op == dbr_pkg::DBR_OP_HALT)
    && step.code_match && !resume_suppress_flag |=> exc.code_fault && !exc.other_fault)
    else $error("port or halt breakpoint not taken first");
  rf_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    step_done && !flags_restore |=> !resume_suppress_flag)
    else $error("resume flag not cleared");
  smm_block_a: assert property (@(posedge ref_clk) disable iff (rst)
    management_interrupt && !system_management_state |=> nmi_blocked && system_management_state)
    else $error("nmi not blocked on entry");
  io_restart_a: assert property (@(posedge ref_clk) disable iff (rst)
    management_interrupt && !system_management_state && step.valid
    && step.op == dbr_pkg::DBR_OP_PORT && ctrl_reg[dbr_pkg::CTRL_IO_RESTART] |=> io_smi_reg)
    else $error("port restart not recorded");
  allow_reen_a: assert property (@(posedge ref_clk) disable iff (rst)
    system_management_state && !management_mode_return && maskable_allow && maskable_deliver
    |=> !nmi_blocked)
    else $error("delivered interrupt did not re-enable nmi");
  exc_reen_a: assert property (@(posedge ref_clk) disable iff (rst)
    system_management_state && !management_mode_return && exc_next.other_fault
    |=> !nmi_blocked)
    else $error("fault did not re-enable nmi");
  trap_reen_a: assert property (@(posedge ref_clk) disable iff (rst)
    system_management_state && !management_mode_return && step.valid && step.code_match
    && !resume_suppress_flag |=> !nmi_blocked)
    else $error("breakpoint did not re-enable nmi");
  irq_level_a: assert property (@(posedge ref_clk) disable iff (rst)
    (|(ev_reg & en_reg)) |=> irq)
    else $error("enabled event did not raise irq");

endmodule : dbr_seq

//--- dbr_pkg.sv
// Package for the debug break and resume sequencing block.
// Assumes a single core clock and a synchronous active-high reset.
package dbr_pkg;

  // Register word offsets (plain register port, 4-bit word address)
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_ST = 4'h2;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CL = 4'h4;

  // Control register fields
  localparam int CTRL_IO_RESTART = 0;
  localparam int CTRL_AUTO_SUPP  = 1;

  // Interrupt status fields
  localparam int EV_CODE_BRK  = 0;
  localparam int EV_DATA_BRK  = 1;
  localparam int EV_SMM_ENTRY = 2;
  localparam int EV_NMI_REEN  = 3;
  localparam int EV_WIDTH     = 4;

  localparam logic [1:0]          CTRL_RESET = 2'h0;
  localparam logic [EV_WIDTH-1:0] EV_RESET   = 4'h0;

  // Instruction classes presented by the decoder
  typedef enum logic [2:0] {
    DBR_OP_PLAIN = 3'b000,
    DBR_OP_PORT  = 3'b001,
    DBR_OP_SIN   = 3'b010,
    DBR_OP_SOUT  = 3'b011,
    DBR_OP_HALT  = 3'b100
  } dbr_op_t;

  // One instruction step as seen by the sequencer
  typedef struct packed {
    logic    valid;        // Instruction about to execute
    dbr_op_t op;
    logic    code_match;   // Armed code breakpoint matches this instruction
    logic    other_fault;  // Page or protection fault on this instruction
    logic    data_match;   // Current iteration touched a data breakpoint
    logic    last_iter;    // Final iteration of a repeated string op
  } dbr_step_t;

  // Exception outcomes reported to the core
  typedef struct packed {
    logic code_fault;      // Instruction breakpoint fault, vector 1
    logic data_trap;       // Memory breakpoint trap, vector 1
    logic other_fault;     // Non-debug fault taken
    logic stack_rf;        // Resume flag value pushed in the stacked image
  } dbr_exc_t;

endpackage : dbr_pkg

//--- dbr_seq_tb_top.sv
// Self-checking bench for the debug break and resume sequencer.
// Assumes dbr_pkg and dbr_seq are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
module dbr_seq_tb_top;
  typedef struct packed {
    logic            rf;
    dbr_pkg::dbr_op_t op;
    logic [3:0]      f;
    logic [2:0]      e;
  } dbr_row_t;
  logic                ref_clk = 1'b0;
  logic                rst = 1'b1;
  dbr_pkg::dbr_step_t  step = '0;
  logic                step_done = 1'b0;
  logic                flags_restore = 1'b0;
  logic                restore_rf = 1'b0;
  logic                maskable_allow = 1'b0;
  logic                maskable_deliver = 1'b0;
  logic                mgmt_int = 1'b0;
  logic                mgmt_ret = 1'b0;
  logic [3:0]          reg_addr = 4'h0;
  logic [31:0]         reg_wdata = 32'h0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [31:0]         reg_rdata;
  dbr_pkg::dbr_exc_t   exc;
  logic                rsf;
  logic                sms;
  logic                nmi_blk;
  logic                irq;
  int                  n_fail = 0;
  int                  n_tests = 0;
  // Flag bits in a row: code match, other fault, data match, last iteration
  dbr_row_t rows [8] = '{
    '{1'b0, dbr_pkg::DBR_OP_PLAIN, 4'h8, 3'h4}, '{1'b1, dbr_pkg::DBR_OP_PLAIN, 4'h8, 3'h0},
    '{1'b0, dbr_pkg::DBR_OP_PORT, 4'h8, 3'h4}, '{1'b0, dbr_pkg::DBR_OP_HALT, 4'h8, 3'h4},
    '{1'b0, dbr_pkg::DBR_OP_SOUT, 4'h2, 3'h2}, '{1'b0, dbr_pkg::DBR_OP_PLAIN, 4'h4, 3'h1},
    '{1'b0, dbr_pkg::DBR_OP_PLAIN, 4'hC, 3'h4}, '{1'b0, dbr_pkg::DBR_OP_SIN, 4'h3, 3'h2}};
  dbr_pkg::dbr_op_t ops [2] = '{dbr_pkg::DBR_OP_PORT, dbr_pkg::DBR_OP_HALT};

  dbr_seq u_dut (
    .ref_clk(ref_clk), .rst(rst), .step(step), .step_done(step_done),
    .flags_restore(flags_restore), .restore_rf(restore_rf), .maskable_allow(maskable_allow),
    .maskable_deliver(maskable_deliver), .management_interrupt(mgmt_int),
    .management_mode_return(mgmt_ret), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exc(exc),
    .resume_suppress_flag(rsf), .system_management_state(sms), .nmi_blocked(nmi_blk),
    .irq(irq)
  );

  always #5 ref_clk = ~ref_clk;

  task automatic finish_test;
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // k: 0 done, 1 restore, 2 deliver, 3 enter, 4 return
  task automatic pulse(input int k, input logic v);
    @(posedge ref_clk);
    restore_rf <= v;
    case (k)
      0: step_done <= 1'b1;
      1: flags_restore <= 1'b1;
      2: maskable_deliver <= 1'b1;
      3: mgmt_int <= 1'b1;
      default: mgmt_ret <= 1'b1;
    endcase
    @(posedge ref_clk);
    {step_done, flags_restore, maskable_deliver, mgmt_int, mgmt_ret} <= 5'h00;
    #1;
  endtask : pulse

  // Exception outcome shows one cycle after the step and only then
  task automatic do_step(input dbr_pkg::dbr_op_t op, input logic [3:0] f, input logic [2:0] e);
    @(posedge ref_clk);
    step <= {1'b1, op, f};
    @(posedge ref_clk);
    step <= '0;
    #1;
    chk("exc", {29'h0, e}, {29'h0, exc.code_fault, exc.data_trap, exc.other_fault});
  endtask : do_step

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("Error watchdog expected done seen timeout");
    finish_test();
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk("outputs", 32'h0, {exc, rsf, sms, nmi_blk, irq});
    rd(dbr_pkg::ADDR_CTRL, {30'h0, dbr_pkg::CTRL_RESET});
    rd(dbr_pkg::ADDR_IRQ_EN, {28'h0, dbr_pkg::EV_RESET});
    $display("Test reset done");
    foreach (rows[i])
    begin
      pulse(1, rows[i].rf);
      chk("resume_flag", {31'h0, rows[i].rf}, {31'h0, rsf});
      do_step(rows[i].op, rows[i].f, rows[i].e);
      pulse(0, 1'b0);
      chk("resume_flag", 32'h0, {31'h0, rsf});
    end
    $display("Test table done");
    wr(dbr_pkg::ADDR_IRQ_CL, 32'h0000000F);
    rd(dbr_pkg::ADDR_IRQ_ST, 32'h0);
    do_step(dbr_pkg::DBR_OP_PLAIN, 4'h8, 3'h4);
    rd(dbr_pkg::ADDR_IRQ_ST, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    wr(dbr_pkg::ADDR_IRQ_EN, 32'h1);
    pulse(0, 1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    wr(dbr_pkg::ADDR_IRQ_ST, 32'h0);
    rd(dbr_pkg::ADDR_IRQ_ST, 32'h1);
    wr(dbr_pkg::ADDR_IRQ_CL, 32'h1);
    pulse(0, 1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    rd(dbr_pkg::ADDR_IRQ_ST, 32'h0);
    rd(4'hF, 32'h0);
    rd(dbr_pkg::ADDR_IRQ_EN, 32'h1);
    $display("Test registers done");
    // A suppressed breakpoint that meets another fault comes back once
    pulse(1, 1'b1);
    do_step(dbr_pkg::DBR_OP_PLAIN, 4'hC, 3'h1);
    chk("stack_rf", 32'h0, {31'h0, exc.stack_rf});
    pulse(1, 1'b1);
    do_step(dbr_pkg::DBR_OP_PLAIN, 4'h8, 3'h4);
    pulse(1, 1'b1);
    do_step(dbr_pkg::DBR_OP_PLAIN, 4'h8, 3'h0);
    pulse(0, 1'b0);
    do_step(dbr_pkg::DBR_OP_SIN, 4'h2, 3'h0);
    do_step(dbr_pkg::DBR_OP_SIN, 4'h0, 3'h2);
    $display("Test repeat and string input done");
    wr(dbr_pkg::ADDR_CTRL, 32'h3);
    rd(dbr_pkg::ADDR_CTRL, 32'h3);
    foreach (ops[i])
    begin
      do_step(ops[i], 4'h8, 3'h4);
      pulse(3, 1'b0);
      chk("mgmt_nmi", 32'h3, {30'h0, sms, nmi_blk});
      pulse(4, 1'b0);
      chk("mgmt_state", 32'h0, {31'h0, sms});
      do_step(ops[i], 4'h8, 3'h4);
    end
    // Entry taken while a port step is on the decoder
    @(posedge ref_clk);
    step     <= {1'b1, dbr_pkg::DBR_OP_PORT, 4'h0};
    mgmt_int <= 1'b1;
    @(posedge ref_clk);
    step     <= '0;
    mgmt_int <= 1'b0;
    rd(dbr_pkg::ADDR_STATUS, 32'h16);
    @(posedge ref_clk);
    maskable_allow <= 1'b1;
    pulse(0, 1'b0);
    chk("nmi_blocked", 32'h1, {31'h0, nmi_blk});
    pulse(2, 1'b0);
    chk("nmi_blocked", 32'h0, {31'h0, nmi_blk});
    @(posedge ref_clk);
    maskable_allow <= 1'b0;
    pulse(4, 1'b0);
    pulse(3, 1'b0);
    do_step(dbr_pkg::DBR_OP_PLAIN, 4'h4, 3'h1);
    chk("stack_rf", 32'h1, {31'h0, exc.stack_rf});
    chk("nmi_blocked", 32'h0, {31'h0, nmi_blk});
    pulse(4, 1'b0);
    pulse(3, 1'b0);
    do_step(dbr_pkg::DBR_OP_PLAIN, 4'h8, 3'h4);
    chk("nmi_blocked", 32'h0, {31'h0, nmi_blk});
    pulse(4, 1'b0);
    rd(dbr_pkg::ADDR_IRQ_ST, 32'hF);
    $display("Test management mode done");
    finish_test();
  end
endmodule : dbr_seq_tb_top
